// [pcnt_pkg.sv]
// Shared constants for the four-channel pulse counter.
`default_nettype none
package pcnt_pkg;
    localparam int NCH        = 4;
    localparam int CNT_W      = 32;
    localparam int ADDR_W     = 12;
    localparam int FILT_CYC_W = 24;
    localparam int SLOT_W     = 4;
    localparam int DOCH_W     = 5;
    localparam int ACFG_W     = 13;
    // Filter inputs: up levels, B-pair levels, B-pair connected, level jumper.
    localparam int IN_N       = 13;
    localparam int IN_B_LSB   = 4;
    localparam int IN_CON_LSB = 8;
    localparam int IN_TTL     = 12;

    // Clock rate and times.
    localparam int CLK_MHZ       = 250;
    localparam int CYC_PER_US    = CLK_MHZ;
    localparam logic [15:0] FILT_MIN_US = 16'd8;
    localparam logic [15:0] FILT_MAX_US = 16'd65000;
    localparam int MAX_CNT_HZ    = 5000;
    localparam int MIN_CNT_PW_US = 100;
    localparam int MAX_FREQ_HZ   = 1000;
    localparam int MIN_FREQ_PW_US = 500;
    localparam int MIN_FREQ_MHZ  = 300;
    localparam logic [31:0] PERIOD_LIMIT =
        32'(64'(CLK_MHZ) * 64'd1000000000 / 64'(MIN_FREQ_MHZ));

    // Register byte offsets.
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_FILT    = 12'h004;
    localparam logic [11:0] OFS_STAT    = 12'h008;
    localparam logic [11:0] OFS_CLR     = 12'h00c;
    localparam logic [11:0] OFS_RESTART = 12'h010;
    localparam logic [4:0]  CH_BLOCK    = 5'h01;
    localparam logic [4:0]  CH_CNT      = 5'h00;
    localparam logic [4:0]  CH_OVF      = 5'h04;
    localparam logic [4:0]  CH_INIT     = 5'h08;
    localparam logic [4:0]  CH_HI       = 5'h0c;
    localparam logic [4:0]  CH_LO       = 5'h10;
    localparam logic [4:0]  CH_ACFG     = 5'h14;
    localparam logic [4:0]  CH_PER      = 5'h18;

    // Alarm configuration fields.
    localparam int ACFG_LATCH    = 0;
    localparam int ACFG_MAP      = 1;
    localparam int ACFG_SLOT_LSB = 4;
    localparam int ACFG_CHAN_LSB = 8;

    // Modes and reset values.
    localparam logic [1:0]  MODE_UPDN  = 2'h0;
    localparam logic [1:0]  MODE_BIDIR = 2'h1;
    localparam logic [1:0]  MODE_FREQ  = 2'h2;
    localparam logic [31:0] CNT_MAX    = 32'hffffffff;
    localparam logic [31:0] CNT_MIN    = 32'h00000000;
    localparam logic [31:0] HI_RST     = 32'hffffffff;
endpackage
`default_nettype wire

// [pcnt_in_if.sv]
// Filtered field levels and edges passed from the input filter to its users.
`default_nettype none
interface pcnt_in_if;
    import pcnt_pkg::*;
    logic [IN_N-1:0]       lvl;
    logic [IN_N-1:0]       rise;
    logic [FILT_CYC_W-1:0] filt_cyc;
    modport filt (input filt_cyc, output lvl, output rise);
    modport core (output filt_cyc, input lvl, input rise);
    modport per  (input rise);
endinterface
`default_nettype wire

// [pcnt_inflt.sv]
// Synchronisers and digital noise filters for all field inputs.
`default_nettype none
module pcnt_inflt
    import pcnt_pkg::*;
#(
    parameter int N = IN_N
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // Raw pin levels
    input  wire logic [N-1:0] raw,
    // Filtered side
    pcnt_in_if.filt           fo
);
    typedef struct packed {
        logic [N-1:0]                 s1;
        logic [N-1:0]                 s2;
        logic [N-1:0]                 s3;
        logic [N-1:0]                 lvl;
        logic [N-1:0]                 rise;
        logic [N-1:0][FILT_CYC_W-1:0] cnt;
    } pcnt_flt_t;

    pcnt_flt_t q_ff;
    pcnt_flt_t nxt_q;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_q      = q_ff;
        nxt_q.s1   = raw;
        nxt_q.s2   = q_ff.s1;
        nxt_q.s3   = q_ff.s2;
        nxt_q.rise = '0;
        for (int i = 0; i < N; i++) begin
            // A new level counts only once it has held for the whole filter time.
            if (q_ff.s2[i] != q_ff.s3[i] || q_ff.s3[i] == q_ff.lvl[i]) begin
                nxt_q.cnt[i] = '0; // RL23
            end else if (q_ff.cnt[i] >= fo.filt_cyc - 24'h1) begin
                nxt_q.lvl[i]  = q_ff.s3[i]; // RL17
                nxt_q.rise[i] = q_ff.s3[i];
                nxt_q.cnt[i]  = '0;
            end else begin
                nxt_q.cnt[i] = q_ff.cnt[i] + 24'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= '0;
        end else if (ce) begin
            q_ff <= nxt_q;
        end
    end

    assign fo.lvl  = q_ff.lvl;
    assign fo.rise = q_ff.rise;

    ////////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < N; i++) begin : g_chk
        property p_flt_hold;
            @(posedge pclk) disable iff (!presetn)
            $changed(q_ff.lvl[i]) |-> $past(q_ff.cnt[i]) == $past(fo.filt_cyc) - 24'h1;
        endproperty
        a_flt_hold: assert property (p_flt_hold) else $error("level moved before filter time"); // RL23
    end
endmodule // pcnt_inflt
`default_nettype wire

// [pcnt_per.sv]
// Period measurement between filtered up-input edges for frequency readout.
`default_nettype none
module pcnt_per
    import pcnt_pkg::*;
(
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      ce,
    // Edges
    pcnt_in_if.per                         fi,
    // Last period in clock cycles, zero when slower than the lowest rate
    output logic [NCH-1:0][CNT_W-1:0]      period
);
    typedef struct packed {
        logic [NCH-1:0][CNT_W-1:0] run;
        logic [NCH-1:0][CNT_W-1:0] per;
        logic [NCH-1:0]            seen;
    } pcnt_per_t;

    pcnt_per_t q_ff;
    pcnt_per_t nxt_q;

    always_comb begin
        nxt_q = q_ff;
        for (int c = 0; c < NCH; c++) begin
            if (fi.rise[c]) begin
                nxt_q.per[c]  = q_ff.seen[c] ? q_ff.run[c] + 32'h1 : '0;
                nxt_q.run[c]  = '0;
                nxt_q.seen[c] = 1'b1;
            end else if (q_ff.run[c] >= PERIOD_LIMIT) begin
                // Below the lowest measurable rate the reading drops to zero.
                nxt_q.per[c]  = '0; // RL19
                nxt_q.seen[c] = 1'b0;
            end else begin
                nxt_q.run[c] = q_ff.run[c] + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= '0;
        end else if (ce) begin
            q_ff <= nxt_q;
        end
    end

    assign period = q_ff.per;
endmodule // pcnt_per
`default_nettype wire

// [pcnt_top.sv]
// Four-channel pulse counter with APB registers, alarms and output mapping.
`default_nettype none
// Contract
// RL1: one mode shared by all four channels
// RL2: up/down mode: up pulse adds one
// RL3: up/down mode: down pulse subtracts one
// RL4: simultaneous up and down pulses hold value
// RL5: bi-direction: direction high counts up
// RL6: bi-direction: direction low counts down
// RL7: open direction pair follows input-level jumper
// RL8: frequency mode counts up input only
// RL9: signed overflow count follows range crossings
// RL10: crossing range reloads the initial value
// RL11: range fixed from zero to all ones
// RL12: high alarm either disabled or latching
// RL13: high limit spans full 32 bits
// RL14: alarm routed to mapped output slot, channel
// RL15: clear control releases latch, self-reverts
// RL16: host sets limits and initial value first
// RL17: programmable noise filter 8 to 65000 us
// RL18: counts 5 kHz pulses, 100 us wide
// RL19: measures 0.3 to 1000 Hz
// RL20: latched alarm holds until cleared
// RL21: high above limit, low below limit
// RL22: counter, initial, signed overflow readable
// RL23: pulse counts after filter-time stable level
module pcnt_top
    import pcnt_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         ce,
    // APB slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [pcnt_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // Field inputs; the B pair doubles as the direction pair
    input  wire logic [pcnt_pkg::NCH-1:0]     up_count_input_pos,
    input  wire logic [pcnt_pkg::NCH-1:0]     up_count_input_neg,
    input  wire logic [pcnt_pkg::NCH-1:0]     down_count_input_pos,
    input  wire logic [pcnt_pkg::NCH-1:0]     down_count_input_neg,
    input  wire logic                         input_level_ttl,
    // Alarm state and digital output mapping
    output logic      [pcnt_pkg::NCH-1:0]     high_alarm,
    output logic      [pcnt_pkg::NCH-1:0]     low_alarm,
    output logic      [pcnt_pkg::NCH-1:0]     do_alarm,
    output logic      [pcnt_pkg::NCH-1:0][pcnt_pkg::SLOT_W-1:0] do_slot,
    output logic      [pcnt_pkg::NCH-1:0][pcnt_pkg::DOCH_W-1:0] do_chan
);
    import pcnt_pkg::*;

    typedef struct packed {
        logic [1:0]                 mode;
        logic [15:0]                filt_us;
        logic [FILT_CYC_W-1:0]      filt_cyc;
        logic [NCH-1:0][CNT_W-1:0]  cnt;
        logic [NCH-1:0][CNT_W-1:0]  ovf;
        logic [NCH-1:0][CNT_W-1:0]  init;
        logic [NCH-1:0][CNT_W-1:0]  hi;
        logic [NCH-1:0][CNT_W-1:0]  lo;
        logic [NCH-1:0][ACFG_W-1:0] acfg;
        logic [NCH-1:0]             clr;
        logic [NCH-1:0]             hi_lat;
        logic [NCH-1:0]             lo_lat;
        logic [NCH-1:0]             do_drv;
        logic [31:0]                prdata;
        logic                       slverr;
    } pcnt_regs_t;

    pcnt_regs_t q_ff;
    pcnt_regs_t nxt_q;

    pcnt_in_if                 fin ();
    logic [IN_N-1:0]           raw_lvl;
    logic [NCH-1:0][CNT_W-1:0] period;
    logic [NCH-1:0]            inc_w;
    logic [NCH-1:0]            dec_w;
    logic [NCH-1:0]            dir_w;
    logic [NCH-1:0]            rst_w;
    logic [NCH-1:0]            clr_wr;
    logic [NCH-1:0]            hi_c;
    logic [NCH-1:0]            lo_c;
    logic                      wr_en;
    logic                      setup;
    logic [1:0]                ch_sel;
    logic [4:0]                ch_ofs;
    logic                      ch_hit;
    logic [31:0]               rdat;
    logic                      rerr;
    logic [15:0]               wfilt;

    ////////////////////////////////////////////////////////////////////////////
    // Pair levels are formed before synchronising; a brief glitch while the
    // two pins cross is absorbed by the noise filter.
    always_comb begin
        raw_lvl = '0;
        for (int c = 0; c < NCH; c++) begin
            raw_lvl[c]              = up_count_input_pos[c] & ~up_count_input_neg[c];
            raw_lvl[IN_B_LSB + c]   = down_count_input_pos[c] & ~down_count_input_neg[c];
            raw_lvl[IN_CON_LSB + c] = down_count_input_pos[c] ^ down_count_input_neg[c];
        end
        raw_lvl[IN_TTL] = input_level_ttl;
    end

    pcnt_inflt #(
        .N       (IN_N)
    ) u_inflt (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .raw     (raw_lvl),
        .fo      (fin.filt)
    );

    pcnt_per u_per (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .fi      (fin.per),
        .period  (period)
    );

    assign fin.filt_cyc = q_ff.filt_cyc;

    ////////////////////////////////////////////////////////////////////////////
    // Zero-wait slave; a low clock enable stretches the access instead.
    assign pready  = ce;
    assign pslverr = q_ff.slverr;
    assign prdata  = q_ff.prdata;
    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pwrite & ce;
    assign ch_sel  = paddr[6:5];
    assign ch_ofs  = paddr[4:0];
    assign ch_hit  = paddr[11:7] == CH_BLOCK;

    always_comb begin
        rdat = '0;
        rerr = 1'b0;
        if (ch_hit) begin
            case (ch_ofs)
                CH_CNT:  rdat = q_ff.cnt[ch_sel]; // RL22
                CH_OVF:  rdat = q_ff.ovf[ch_sel];
                CH_INIT: rdat = q_ff.init[ch_sel];
                CH_HI:   rdat = q_ff.hi[ch_sel];
                CH_LO:   rdat = q_ff.lo[ch_sel];
                CH_ACFG: rdat = {19'h0, q_ff.acfg[ch_sel]};
                CH_PER:  rdat = period[ch_sel];
                default: rerr = 1'b1;
            endcase
        end else begin
            case (paddr)
                OFS_CTRL:    rdat = {30'h0, q_ff.mode};
                OFS_FILT:    rdat = {16'h0, q_ff.filt_us};
                OFS_STAT:    rdat = {23'h0, fin.lvl[IN_TTL], q_ff.lo_lat, q_ff.hi_lat};
                OFS_CLR:     rdat = {28'h0, q_ff.clr};
                OFS_RESTART: rdat = '0;
                default:     rerr = 1'b1;
            endcase
        end
    end

    always_comb begin
        wfilt = pwdata[15:0];
        if (wfilt < FILT_MIN_US) begin
            wfilt = FILT_MIN_US;
        end else if (wfilt > FILT_MAX_US) begin
            wfilt = FILT_MAX_US;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            rst_w[c]  = wr_en && paddr == OFS_RESTART && pwdata[c];
            clr_wr[c] = wr_en && paddr == OFS_CLR && pwdata[c];
            hi_c[c]   = q_ff.cnt[c] > q_ff.hi[c]; // RL21
            lo_c[c]   = q_ff.cnt[c] < q_ff.lo[c];
            // An open direction pair reads as the jumper level.
            dir_w[c]  = fin.lvl[IN_CON_LSB + c] ? fin.lvl[IN_B_LSB + c] : fin.lvl[IN_TTL]; // RL7
            case (q_ff.mode) // RL1
                MODE_UPDN: begin
                    inc_w[c] = fin.rise[c] & ~fin.rise[IN_B_LSB + c]; // RL2 RL4
                    dec_w[c] = fin.rise[IN_B_LSB + c] & ~fin.rise[c]; // RL3
                end
                MODE_BIDIR: begin
                    inc_w[c] = fin.rise[c] & dir_w[c]; // RL5
                    dec_w[c] = fin.rise[c] & ~dir_w[c]; // RL6
                end
                MODE_FREQ: begin
                    inc_w[c] = fin.rise[c]; // RL8
                    dec_w[c] = 1'b0;
                end
                default: begin
                    inc_w[c] = 1'b0;
                    dec_w[c] = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_q          = q_ff;
        nxt_q.filt_cyc = FILT_CYC_W'(q_ff.filt_us * CYC_PER_US); // RL17
        if (setup) begin
            nxt_q.prdata = rdat;
            nxt_q.slverr = rerr;
        end
        if (wr_en && !ch_hit) begin
            case (paddr)
                OFS_CTRL: nxt_q.mode    = pwdata[1:0]; // RL1
                OFS_FILT: nxt_q.filt_us = wfilt; // RL17
                default:  ;
            endcase
        end
        for (int c = 0; c < NCH; c++) begin
            if (wr_en && ch_hit && ch_sel == 2'(c)) begin
                case (ch_ofs)
                    CH_INIT: nxt_q.init[c] = pwdata;
                    CH_HI:   nxt_q.hi[c]   = pwdata; // RL13
                    CH_LO:   nxt_q.lo[c]   = pwdata;
                    CH_ACFG: nxt_q.acfg[c] = pwdata[ACFG_W-1:0]; // RL12 RL14
                    default: ;
                endcase
            end
            // One step per clock, far faster than any legal field pulse rate.
            if (rst_w[c]) begin
                nxt_q.cnt[c] = q_ff.init[c];
                nxt_q.ovf[c] = '0;
            end else if (inc_w[c]) begin // RL18
                if (q_ff.cnt[c] == CNT_MAX) begin // RL11
                    nxt_q.cnt[c] = q_ff.init[c]; // RL10
                    nxt_q.ovf[c] = q_ff.ovf[c] + 32'h1; // RL9
                end else begin
                    nxt_q.cnt[c] = q_ff.cnt[c] + 32'h1; // RL2
                end
            end else if (dec_w[c]) begin
                if (q_ff.cnt[c] == CNT_MIN) begin // RL11
                    nxt_q.cnt[c] = q_ff.init[c]; // RL10
                    nxt_q.ovf[c] = q_ff.ovf[c] - 32'h1; // RL9
                end else begin
                    nxt_q.cnt[c] = q_ff.cnt[c] - 32'h1; // RL3
                end
            end
            // Clear takes effect one cycle after the write, then reverts; a
            // condition still present in that cycle sets the latch again.
            nxt_q.clr[c] = clr_wr[c]; // RL15
            if (!q_ff.acfg[c][ACFG_LATCH]) begin
                nxt_q.hi_lat[c] = 1'b0; // RL12
                nxt_q.lo_lat[c] = 1'b0;
            end else if (q_ff.clr[c]) begin
                nxt_q.hi_lat[c] = hi_c[c]; // RL15
                nxt_q.lo_lat[c] = lo_c[c];
            end else begin
                nxt_q.hi_lat[c] = q_ff.hi_lat[c] | hi_c[c]; // RL20 RL21
                nxt_q.lo_lat[c] = q_ff.lo_lat[c] | lo_c[c];
            end
            nxt_q.do_drv[c] = nxt_q.hi_lat[c] & q_ff.acfg[c][ACFG_MAP]; // RL14
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff         <= '0;
            q_ff.mode    <= MODE_UPDN;
            q_ff.filt_us <= FILT_MIN_US;
            q_ff.hi      <= {NCH{HI_RST}};
        end else if (ce) begin
            q_ff <= nxt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign high_alarm = q_ff.hi_lat;
    assign low_alarm  = q_ff.lo_lat;
    assign do_alarm   = q_ff.do_drv;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            do_slot[c] = q_ff.acfg[c][ACFG_SLOT_LSB +: SLOT_W]; // RL14
            do_chan[c] = q_ff.acfg[c][ACFG_CHAN_LSB +: DOCH_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_filt_range;
        q_ff.filt_us >= FILT_MIN_US && q_ff.filt_us <= FILT_MAX_US;
    endproperty
    a_filt_range: assert property (p_filt_range) else $error("filter time out of range"); // RL17

    for (genvar c = 0; c < NCH; c++) begin : g_chk
        sequence s_step_up;
            ce && inc_w[c] && !rst_w[c];
        endsequence
        sequence s_clear;
            ce && q_ff.clr[c] && q_ff.acfg[c][ACFG_LATCH] && !hi_c[c];
        endsequence

        property p_up_inc;
            s_step_up and (q_ff.cnt[c] != CNT_MAX) |=> q_ff.cnt[c] == $past(q_ff.cnt[c]) + 32'h1;
        endproperty
        a_up_inc: assert property (p_up_inc) else $error("up step did not add one"); // RL2

        property p_dn_dec;
            ce && dec_w[c] && !rst_w[c] && q_ff.cnt[c] != CNT_MIN |=>
                q_ff.cnt[c] == $past(q_ff.cnt[c]) - 32'h1;
        endproperty
        a_dn_dec: assert property (p_dn_dec) else $error("down step did not subtract one"); // RL3

        property p_both_hold;
            ce && q_ff.mode == MODE_UPDN && fin.rise[c] && fin.rise[IN_B_LSB + c] && !rst_w[c]
                |=> $stable(q_ff.cnt[c]);
        endproperty
        a_both_hold: assert property (p_both_hold) else $error("both pulses changed count"); // RL4

        property p_bidir;
            q_ff.mode == MODE_BIDIR && fin.rise[c] |-> inc_w[c] == dir_w[c] && dec_w[c] == !dir_w[c];
        endproperty
        a_bidir: assert property (p_bidir) else $error("direction level not obeyed"); // RL5 RL6

        property p_freq_up;
            q_ff.mode == MODE_FREQ |-> !dec_w[c] && inc_w[c] == fin.rise[c];
        endproperty
        a_freq_up: assert property (p_freq_up) else $error("frequency mode counted down"); // RL8

        property p_wrap_up;
            s_step_up and (q_ff.cnt[c] == CNT_MAX) |=>
                q_ff.cnt[c] == $past(q_ff.init[c]) && q_ff.ovf[c] == $past(q_ff.ovf[c]) + 32'h1;
        endproperty
        a_wrap_up: assert property (p_wrap_up) else $error("overflow wrap wrong"); // RL9 RL10

        property p_wrap_dn;
            ce && dec_w[c] && !rst_w[c] && q_ff.cnt[c] == CNT_MIN |=>
                q_ff.cnt[c] == $past(q_ff.init[c]) && q_ff.ovf[c] == $past(q_ff.ovf[c]) - 32'h1;
        endproperty
        a_wrap_dn: assert property (p_wrap_dn) else $error("underflow wrap wrong"); // RL9 RL10

        property p_clear;
            s_clear |=> !q_ff.hi_lat[c] && !q_ff.clr[c];
        endproperty
        a_clear: assert property (p_clear) else $error("latched alarm not released"); // RL15

        property p_hold;
            ce && q_ff.hi_lat[c] && q_ff.acfg[c][ACFG_LATCH] && !q_ff.clr[c] |=> q_ff.hi_lat[c];
        endproperty
        a_hold: assert property (p_hold) else $error("latched alarm dropped"); // RL20

        property p_raise;
            ce && hi_c[c] && q_ff.acfg[c][ACFG_LATCH] |=> q_ff.hi_lat[c] ##1 q_ff.do_drv[c] ||
                !q_ff.acfg[c][ACFG_MAP] || !q_ff.hi_lat[c] || !ce;
        endproperty
        a_raise: assert property (p_raise) else $error("high alarm not raised"); // RL21 RL14
    end
endmodule // pcnt_top
`default_nettype wire

// [pcnt_field_model.sv]
// Field pulse source model driving the counter's differential input pairs.
`default_nettype none
module pcnt_field_model (
    // Clock
    input  wire logic       pclk,
    // Field pairs and level jumper
    output var  logic [3:0] up_p,
    output var  logic [3:0] up_n,
    output var  logic [3:0] dn_p,
    output var  logic [3:0] dn_n,
    output var  logic       ttl
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins idle as connected pairs at level 0, so reset never sees a stray edge.
    initial begin
        up_p = '0;
        up_n = '1;
        dn_p = '0;
        dn_n = '1;
        ttl = 1'b1;
    end
    // The down pair is only touched on bits in d, so a direction set by dir survives a pulse.
    task automatic pulse(input logic [3:0] u, input logic [3:0] d, input int w);
        @(posedge pclk);
        up_p <= u;
        up_n <= ~u;
        dn_p <= dn_p | d;
        dn_n <= dn_n & ~d;
        repeat (w) @(posedge pclk);
        up_p <= '0;
        up_n <= '1;
        dn_p <= dn_p & ~d;
        dn_n <= dn_n | d;
        repeat (2100) @(posedge pclk);
    endtask
    task automatic dir(input logic [3:0] p, input logic [3:0] n);
        @(posedge pclk);
        dn_p <= p;
        dn_n <= n;
        repeat (2100) @(posedge pclk);
    endtask
endmodule // pcnt_field_model
`default_nettype wire

// [pcnt_top_tb.sv]
// Self-checking bench for the four-channel pulse counter.
`default_nettype none
module pcnt_top_tb;
    import pcnt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, ttl;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [3:0]      up_p, up_n, dn_p, dn_n, hi_al, lo_al, do_al;
    logic [3:0][3:0] do_slot;
    logic [3:0][4:0] do_chan;
    int              n_mismatch, samples_checked;
    ////////////////////////////////////////////////////////////
    pcnt_top pcnt_top_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .up_count_input_pos(up_p), .up_count_input_neg(up_n), .down_count_input_pos(dn_p),
        .down_count_input_neg(dn_n), .input_level_ttl(ttl), .high_alarm(hi_al), .low_alarm(lo_al),
        .do_alarm(do_al), .do_slot(do_slot), .do_chan(do_chan));
    pcnt_field_model pcnt_field_model_i (.pclk(pclk), .up_p(up_p), .up_n(up_n), .dn_p(dn_p), .dn_n(dn_n),
        .ttl(ttl));
    ////////////////////////////////////////////////////////////
    function automatic logic [11:0] ca(input int c, input logic [4:0] o);
        return 12'h080 + 12'(c * 32) + 12'(o);
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        chk(s, e, rd);
    endtask
    task automatic chan_all(input string s, input logic [4:0] o, input logic [31:0] e);
        for (int c = 0; c < 4; c++) begin
            rdchk(s, ca(c, o), e);
        end
    endtask
    task automatic results;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Every pulse but one (100 cycles) is 2100 cycles wide with a 2100-cycle gap, so the whole run stays near fifty thousand cycles.
    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        results;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", OFS_CTRL, 32'h0);
        rdchk("hi", ca(3, CH_HI), CNT_MAX);
        apb(1'b1, OFS_FILT, 32'h4);
        rdchk("filt", OFS_FILT, 32'h8);
        apb(1'b0, 12'hffc, '0);
        chk("slverr", 32'h1, 32'(pslverr));
        chk("pready", 32'h1, 32'(pready));
        pcnt_field_model_i.pulse(4'hf, 4'h0, 2100);
        chan_all("cnt", CH_CNT, 32'h1);
        pcnt_field_model_i.pulse(4'h0, 4'hf, 2100);
        chan_all("cnt", CH_CNT, 32'h0);
        pcnt_field_model_i.pulse(4'hf, 4'hf, 2100);
        pcnt_field_model_i.pulse(4'hf, 4'h0, 100);
        chan_all("cnt", CH_CNT, 32'h0);
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, ca(c, CH_INIT), 32'h5);
        end
        pcnt_field_model_i.pulse(4'h0, 4'hf, 2100);
        chan_all("cnt", CH_CNT, 32'h5);
        chan_all("ovf", CH_OVF, 32'hffffffff);
        apb(1'b1, ca(0, CH_HI), 32'h5);
        apb(1'b1, ca(1, CH_HI), 32'h5);
        apb(1'b1, ca(0, CH_ACFG), 32'h00000b53);
        pcnt_field_model_i.pulse(4'h3, 4'h0, 2100);
        chk("hi_al", 32'h1, 32'(hi_al));
        chk("do_al", 32'h1, 32'(do_al));
        chk("slot", 32'h5, 32'(do_slot[0]));
        chk("chan", 32'hb, 32'(do_chan[0]));
        chk("lo_al", 32'h0, 32'(lo_al));
        apb(1'b1, ca(0, CH_HI), CNT_MAX);
        rdchk("hi", ca(0, CH_HI), CNT_MAX);
        chk("hi_al", 32'h1, 32'(hi_al));
        rdchk("stat", OFS_STAT, 32'h101);
        apb(1'b1, OFS_CLR, 32'h1);
        rdchk("clr", OFS_CLR, 32'h0);
        chk("hi_al", 32'h0, 32'(hi_al));
        apb(1'b1, OFS_RESTART, 32'hf);
        apb(1'b1, OFS_CTRL, {30'h0, MODE_BIDIR});
        pcnt_field_model_i.dir(4'hf, 4'h0);
        pcnt_field_model_i.pulse(4'hf, 4'h0, 2100);
        chan_all("cnt", CH_CNT, 32'h6);
        pcnt_field_model_i.dir(4'h0, 4'hf);
        pcnt_field_model_i.pulse(4'hf, 4'h0, 2100);
        chan_all("cnt", CH_CNT, 32'h5);
        pcnt_field_model_i.dir(4'hf, 4'hf);
        pcnt_field_model_i.pulse(4'hf, 4'h0, 2100);
        chan_all("cnt", CH_CNT, 32'h6);
        apb(1'b1, OFS_CTRL, {30'h0, MODE_FREQ});
        pcnt_field_model_i.pulse(4'hf, 4'hf, 2100);
        chan_all("cnt", CH_CNT, 32'h7);
        chan_all("per", CH_PER, 32'h1078);
        apb(1'b1, OFS_CTRL, 32'h3);
        pcnt_field_model_i.pulse(4'hf, 4'h0, 2100);
        chan_all("cnt", CH_CNT, 32'h7);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", OFS_CTRL, 32'h0);
        results;
    end
endmodule // pcnt_top_tb
`default_nettype wire
